// [src/hsp_map.svh]
// constants for the host serial register port, both ends
//
// What this block does
// - one address byte, then optional single data word
// - streaming: one address, many consecutive data words
// - data words are whole bytes, width per register
// - command addresses: address byte only, acted on
// - device samples command line on clock rise
// - reply bit stable while serial clock high
// - host frames with select low; rise ends frame
// - allow 60 us after write before reuse
// - interrupt raised only for masked-in status bits
// - host reads status after interrupt
// - address then write data, both MSB first
// - read data shifted out MSB first
// - clock idle level irrelevant; select frames transfers
`ifndef HSP_MAP_SVH
`define HSP_MAP_SVH

// ----------------------------------------------------------
// framing
// ----------------------------------------------------------
`define HSP_ADDR_BITS      8
`define HSP_ADDR_MSB       7
`define HSP_BYTE_SHIFT     3

// ----------------------------------------------------------
// timing
// ----------------------------------------------------------
`define HSP_CLK_PERIOD_NS  100
`define HSP_SCLK_PERIOD_NS 800
`define HSP_SCLK_HALF      (`HSP_SCLK_PERIOD_NS / 2 / `HSP_CLK_PERIOD_NS)
`define HSP_MIN_HALF       4
`define HSP_SETTLE_NS      60000
`define HSP_SETTLE_CYC     ((`HSP_SETTLE_NS + `HSP_CLK_PERIOD_NS - 1) / `HSP_CLK_PERIOD_NS)

`endif

// [src/hsp_pkg.sv]
// types shared by both ends of the host serial register port
package hsp_pkg;

   // ----------------------------------------------------------
   // register access kinds
   // ----------------------------------------------------------
   typedef enum logic [1:0] {
      HSP_CMD = 2'h0,
      HSP_WR  = 2'h1,
      HSP_RD  = 2'h2
   } hsp_kind_t;

   // ----------------------------------------------------------
   // state machines
   // ----------------------------------------------------------
   typedef enum logic [5:0] {
      HSP_D_IDLE = 6'h01,
      HSP_D_ADDR = 6'h02,
      HSP_D_DEC  = 6'h04,
      HSP_D_WR   = 6'h08,
      HSP_D_RD   = 6'h10,
      HSP_D_DONE = 6'h20
   } hsp_dev_st_t;

   typedef enum logic [5:0] {
      HSP_H_IDLE = 6'h01,
      HSP_H_SEL  = 6'h02,
      HSP_H_LOW  = 6'h04,
      HSP_H_HIGH = 6'h08,
      HSP_H_END  = 6'h10,
      HSP_H_GAP  = 6'h20
   } hsp_host_st_t;

   // address carries no data phase
   function automatic logic hsp_no_data(input hsp_kind_t k, input logic any_bytes);
      return (k == HSP_CMD) || !any_bytes;
   endfunction

endpackage

// [src/hsp_if.sv]
// link wires between host and device ends
interface hsp_if;
   logic sclk;
   logic select_n;
   logic command_line;
   logic reply_o;
   logic reply_oe;
   logic irq_oe;
   wire  reply;
   wire  irq_n;

   // released reply sits at its pull-up level; interrupt is open drain with pull-up
   assign reply = reply_oe ? reply_o : 1'b1;
   assign irq_n = irq_oe ? 1'b0 : 1'b1;

   modport dev  (input sclk, select_n, command_line, output reply_o, reply_oe, irq_oe);
   modport host (output sclk, select_n, command_line, input reply, irq_n);
endinterface

// [src/hsp_device.sv]
// device end: serial slave giving access to internal registers
`include "hsp_map.svh"

module hsp_device #(
   parameter int DATA_W = 32,
   parameter int BY_W   = 3,
   parameter int IRQ_W  = 8
) (
   // clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   // serial link
   hsp_if.dev                            bus,
   // register access
   output logic [`HSP_ADDR_BITS-1:0]     addr_q,
   input  wire hsp_pkg::hsp_kind_t       reg_kind,
   input  wire logic [BY_W-1:0]          reg_bytes,
   input  wire logic                     reg_stream,
   output logic                          cmd_stb_q,
   output logic                          wr_stb_q,
   output logic [DATA_W-1:0]             wr_data_q,
   output logic                          rd_stb_q,
   input  wire logic [DATA_W-1:0]        rd_data,
   // status and interrupt
   input  wire logic [IRQ_W-1:0]         status_flags,
   input  wire logic [IRQ_W-1:0]         irq_mask
);
   import hsp_pkg::*;

   localparam int              NB_W = $clog2(DATA_W + 1);
   localparam logic [NB_W-1:0] DW   = NB_W'(DATA_W);

   // ----------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------
   if (DATA_W < 8 || DATA_W % 8 != 0 || BY_W != $clog2(DATA_W / 8 + 1)) begin : g_bad_w
      $error("hsp_device: DATA_W must be a multiple of 8 and BY_W match it");
   end
   if (IRQ_W < 1) begin : g_bad_irq
      $error("hsp_device: IRQ_W must be at least 1");
   end

   // ----------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------
   logic sclk_s1;
   logic sclk_s2;
   logic sclk_s3;
   logic sel_s1;
   logic sel_s2;
   logic cmd_s1;
   logic cmd_s2;
   logic sclk_rise;
   logic sclk_fall;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_s3 <= 1'b0;
         sel_s1  <= 1'b1;
         sel_s2  <= 1'b1;
         cmd_s1  <= 1'b0;
         cmd_s2  <= 1'b0;
      end else begin
         sclk_s1 <= bus.sclk;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         sel_s1  <= bus.select_n;
         sel_s2  <= sel_s1;
         cmd_s1  <= bus.command_line;
         cmd_s2  <= cmd_s1;
      end
   end

   // data and clock share the same delay, so they stay aligned
   assign sclk_rise = sclk_s2 & ~sclk_s3;
   assign sclk_fall = ~sclk_s2 & sclk_s3;

   // ----------------------------------------------------------
   // frame state
   // ----------------------------------------------------------
   hsp_dev_st_t               st_q;
   logic [NB_W-1:0]           cnt_q;
   logic [NB_W-1:0]           nbits_q;
   logic                      stream_q;
   logic [`HSP_ADDR_BITS-1:0] ash_q;
   logic [DATA_W-1:0]         wsh_q;
   logic [DATA_W-1:0]         rsh_q;
   logic                      reply_o_q;
   logic                      reply_oe_q;
   logic                      irq_oe_q;
   logic                      addr_last;
   logic                      word_last;
   logic                      no_data;

   assign addr_last = cnt_q == NB_W'(`HSP_ADDR_MSB);
   assign word_last = cnt_q == nbits_q - 1'b1;
   assign no_data   = hsp_no_data(reg_kind, reg_bytes != '0);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_q     <= HSP_D_IDLE;
         cnt_q    <= '0;
         nbits_q  <= '0;
         stream_q <= 1'b0;
      end else if (sel_s2) begin
         // select high ends any frame; a partial word is simply dropped
         st_q  <= HSP_D_IDLE;
         cnt_q <= '0;
      end else begin
         unique case (st_q)
            HSP_D_IDLE: begin
               // clock level at select fall is ignored
               st_q  <= HSP_D_ADDR;
               cnt_q <= '0;
            end
            HSP_D_ADDR: begin
               if (sclk_rise) begin
                  cnt_q <= addr_last ? '0 : cnt_q + 1'b1;
                  if (addr_last) begin
                     st_q <= HSP_D_DEC;
                  end
               end
            end
            HSP_D_DEC: begin
               nbits_q  <= NB_W'(reg_bytes) << `HSP_BYTE_SHIFT;
               stream_q <= reg_stream;
               if (no_data) begin
                  st_q <= HSP_D_DONE;
               end else if (reg_kind == HSP_WR) begin
                  st_q <= HSP_D_WR;
               end else begin
                  st_q <= HSP_D_RD;
               end
            end
            HSP_D_WR, HSP_D_RD: begin
               if (sclk_rise) begin
                  cnt_q <= word_last ? '0 : cnt_q + 1'b1;
                  if (word_last && !stream_q) begin
                     st_q <= HSP_D_DONE;
                  end
               end
            end
            HSP_D_DONE: begin
               // further clocks are ignored until select rises
               cnt_q <= '0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------
   // shift registers
   // ----------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ash_q <= '0;
         wsh_q <= '0;
         rsh_q <= '0;
      end else begin
         if (st_q == HSP_D_ADDR && sclk_rise) begin
            ash_q <= {ash_q[`HSP_ADDR_MSB-1:0], cmd_s2};
         end
         if (st_q == HSP_D_DEC || (sclk_rise && word_last)) begin
            wsh_q <= '0;
         end else if (st_q == HSP_D_WR && sclk_rise) begin
            wsh_q <= {wsh_q[DATA_W-2:0], cmd_s2};
         end
         // left-align so the word's MSB leaves first
         if (rd_stb_q) begin
            rsh_q <= rd_data << (DW - nbits_q);
         end else if (st_q == HSP_D_RD && sclk_fall) begin
            rsh_q <= {rsh_q[DATA_W-2:0], 1'b0};
         end
      end
   end

   // ----------------------------------------------------------
   // register side strobes
   // ----------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         addr_q    <= '0;
         cmd_stb_q <= 1'b0;
         wr_stb_q  <= 1'b0;
         wr_data_q <= '0;
         rd_stb_q  <= 1'b0;
      end else begin
         cmd_stb_q <= !sel_s2 && st_q == HSP_D_DEC && no_data;
         // only a complete word is ever handed over
         wr_stb_q  <= !sel_s2 && st_q == HSP_D_WR && sclk_rise && word_last;
         // streaming read fetches the next word as the last bit goes out
         rd_stb_q  <= !sel_s2 && ((st_q == HSP_D_DEC && !no_data && reg_kind == HSP_RD)
                      || (st_q == HSP_D_RD && sclk_rise && word_last && stream_q));
         if (st_q == HSP_D_ADDR && sclk_rise && addr_last) begin
            addr_q <= {ash_q[`HSP_ADDR_MSB-1:0], cmd_s2};
         end
         if (st_q == HSP_D_WR && sclk_rise && word_last) begin
            wr_data_q <= {wsh_q[DATA_W-2:0], cmd_s2};
         end
      end
   end

   // ----------------------------------------------------------
   // reply line
   // ----------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst || sel_s2) begin
         reply_o_q  <= 1'b0;
         reply_oe_q <= 1'b0;
      end else if (sclk_fall) begin
         // changing on the fall keeps the bit steady through the high phase
         reply_oe_q <= st_q == HSP_D_RD;
         reply_o_q  <= rsh_q[DATA_W-1];
      end
   end

   // ----------------------------------------------------------
   // interrupt
   // ----------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_oe_q <= 1'b0;
      end else begin
         irq_oe_q <= |(status_flags & irq_mask);
      end
   end

   assign bus.reply_o  = reply_o_q;
   assign bus.reply_oe = reply_oe_q;
   assign bus.irq_oe   = irq_oe_q;

endmodule

// [src/hsp_host.sv]
// host end: serial master issuing register transactions
`include "hsp_map.svh"

module hsp_host #(
   parameter int                     DATA_W       = 32,
   parameter int                     BY_W         = 3,
   parameter int                     WC_W         = 8,
   parameter int                     HALF_CYC     = `HSP_SCLK_HALF,
   parameter logic                   SCLK_IDLE    = 1'b0,
   parameter logic [`HSP_ADDR_MSB:0] STATUS_ADDR  = 8'h00,
   parameter int                     STATUS_BYTES = 1
) (
   // clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   // serial link
   hsp_if.host                           bus,
   // request
   input  wire logic                     req_valid,
   output logic                          req_ready_q,
   input  wire hsp_pkg::hsp_kind_t       req_kind,
   input  wire logic [`HSP_ADDR_MSB:0]   req_addr,
   input  wire logic [BY_W-1:0]          req_bytes,
   input  wire logic [WC_W-1:0]          req_words,
   // data
   input  wire logic [DATA_W-1:0]        wr_data,
   output logic                          wr_next_q,
   output logic [DATA_W-1:0]             rd_data_q,
   output logic                          rd_valid_q,
   output logic                          rd_auto_q,
   // interrupt
   output logic                          irq_seen_q
);
   import hsp_pkg::*;

   localparam int              NB_W = $clog2(DATA_W + 1);
   localparam int              TM_W = 16;
   localparam logic [NB_W-1:0] DW   = NB_W'(DATA_W);
   localparam logic [TM_W-1:0] H1   = TM_W'(HALF_CYC - 1);
   localparam logic [TM_W-1:0] ST1  = TM_W'(`HSP_SETTLE_CYC - 1);

   if (DATA_W < 8 || DATA_W % 8 != 0 || BY_W != $clog2(DATA_W / 8 + 1)
       || HALF_CYC < `HSP_MIN_HALF || `HSP_SETTLE_CYC >= 2 ** TM_W
       || STATUS_BYTES < 1 || STATUS_BYTES > DATA_W / 8) begin : g_bad
      $error("hsp_host: unsupported parameter values");
   end

   // ----------------------------------------------------------
   // synchronisers
   // ----------------------------------------------------------
   logic reply_s1;
   logic reply_s2;
   logic irq_s1;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         reply_s1   <= 1'b0;
         reply_s2   <= 1'b0;
         irq_s1     <= 1'b0;
         irq_seen_q <= 1'b0;
      end else begin
         reply_s1   <= bus.reply;
         reply_s2   <= reply_s1;
         irq_s1     <= ~bus.irq_n;
         irq_seen_q <= irq_s1;
      end
   end

   // ----------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------
   hsp_host_st_t      st_q;
   logic [TM_W-1:0]   tmr_q;
   hsp_kind_t         kind_q;
   logic              no_data_q;
   logic [NB_W-1:0]   nbits_q;
   logic [WC_W-1:0]   words_q;
   logic [NB_W-1:0]   cnt_q;
   logic              is_addr_q;
   logic              auto_q;
   logic [DATA_W-1:0] tx_q;
   logic [DATA_W-1:0] rx_q;
   logic [DATA_W-1:0] rx_nx;
   logic [DATA_W-1:0] nxt;
   logic              sclk_q;
   logic              sel_n_q;
   logic              cmd_q;
   logic              tmr_done;
   logic              unit_last;
   logic              frame_last;
   logic              bit_end;
   logic              go_low;
   logic              start;

   assign tmr_done   = tmr_q == '0;
   assign unit_last  = cnt_q == (is_addr_q ? NB_W'(`HSP_ADDR_MSB) : nbits_q - 1'b1);
   assign frame_last = unit_last && (is_addr_q ? no_data_q : words_q == WC_W'(1));
   assign bit_end    = st_q == HSP_H_HIGH && tmr_done;
   assign go_low     = tmr_done && (st_q == HSP_H_SEL || (bit_end && !frame_last));
   // a pending interrupt starts a status read when no request waits
   assign start      = st_q == HSP_H_IDLE && req_ready_q && (req_valid || irq_seen_q);
   assign rx_nx      = {rx_q[DATA_W-2:0], reply_s2};
   assign nxt        = !(bit_end && unit_last) ? tx_q
                       : (kind_q == HSP_WR ? wr_data << (DW - nbits_q) : '0);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_q  <= HSP_H_IDLE;
         tmr_q <= '0;
      end else begin
         if (!tmr_done) begin
            tmr_q <= tmr_q - 1'b1;
         end
         unique case (st_q)
            HSP_H_IDLE: if (start) begin
               st_q  <= HSP_H_SEL;
               tmr_q <= H1;
            end
            HSP_H_SEL: if (tmr_done) begin
               st_q  <= HSP_H_LOW;
               tmr_q <= H1;
            end
            HSP_H_LOW: if (tmr_done) begin
               st_q  <= HSP_H_HIGH;
               tmr_q <= H1;
            end
            HSP_H_HIGH: if (tmr_done) begin
               st_q  <= frame_last ? HSP_H_END : HSP_H_LOW;
               tmr_q <= H1;
            end
            HSP_H_END: if (tmr_done) begin
               // written value may take a while to land inside the device
               st_q  <= HSP_H_GAP;
               tmr_q <= kind_q == HSP_WR ? ST1 : H1;
            end
            HSP_H_GAP: if (tmr_done) begin
               st_q <= HSP_H_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         req_ready_q <= 1'b1;
         kind_q      <= HSP_CMD;
         no_data_q   <= 1'b1;
         nbits_q     <= '0;
         words_q     <= '0;
         auto_q      <= 1'b0;
      end else if (start) begin
         req_ready_q <= 1'b0;
         auto_q      <= !req_valid;
         kind_q      <= req_valid ? req_kind : HSP_RD;
         no_data_q   <= req_valid ? hsp_no_data(req_kind, req_bytes != '0) : 1'b0;
         nbits_q     <= (req_valid ? NB_W'(req_bytes) : NB_W'(STATUS_BYTES))
                        << `HSP_BYTE_SHIFT;
         words_q     <= (!req_valid || req_words == '0) ? WC_W'(1) : req_words;
      end else begin
         if (st_q == HSP_H_GAP && tmr_done) begin
            req_ready_q <= 1'b1;
         end
         if (bit_end && unit_last && !is_addr_q) begin
            words_q <= words_q - 1'b1;
         end
      end
   end

   // ----------------------------------------------------------
   // pins and data path
   // ----------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sclk_q     <= SCLK_IDLE;
         sel_n_q    <= 1'b1;
         cmd_q      <= 1'b0;
         tx_q       <= '0;
         rx_q       <= '0;
         cnt_q      <= '0;
         is_addr_q  <= 1'b1;
         wr_next_q  <= 1'b0;
         rd_valid_q <= 1'b0;
         rd_data_q  <= '0;
         rd_auto_q  <= 1'b0;
      end else begin
         wr_next_q  <= go_low && bit_end && unit_last && kind_q == HSP_WR;
         rd_valid_q <= 1'b0;
         if (start) begin
            sel_n_q   <= 1'b0;
            tx_q      <= DATA_W'(req_valid ? req_addr : STATUS_ADDR) << (DATA_W - `HSP_ADDR_BITS);
            rx_q      <= '0;
            cnt_q     <= '0;
            is_addr_q <= 1'b1;
         end
         if (go_low) begin
            sclk_q <= 1'b0;
            cmd_q  <= nxt[DATA_W-1];
            tx_q   <= nxt << 1;
         end
         if (st_q == HSP_H_LOW && tmr_done) begin
            sclk_q <= 1'b1;
         end
         if (bit_end) begin
            cnt_q <= unit_last ? '0 : cnt_q + 1'b1;
            if (unit_last) begin
               is_addr_q <= 1'b0;
            end
            // sampled at the end of the high phase, well after the device drove it
            if (!is_addr_q && kind_q == HSP_RD) begin
               rx_q <= unit_last ? '0 : rx_nx;
               if (unit_last) begin
                  rd_data_q  <= rx_nx;
                  rd_valid_q <= 1'b1;
                  rd_auto_q  <= auto_q;
               end
            end
            if (frame_last) begin
               sclk_q <= SCLK_IDLE;
            end
         end
         if (st_q == HSP_H_END && tmr_done) begin
            sel_n_q <= 1'b1;
         end
      end
   end

   assign bus.sclk         = sclk_q;
   assign bus.select_n     = sel_n_q;
   assign bus.command_line = cmd_q;

endmodule

// [verification/hsp_link_monitor.sv]
// concurrent checks on the link wires between host and device ends
module hsp_link_monitor (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // link wires
   input wire logic sclk,
   input wire logic select_n,
   input wire logic command_line,
   input wire logic reply_o,
   input wire logic reply_oe
);
   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   logic        sclk_q;
   logic [15:0] rise_cnt_q;

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   always_ff @(posedge core_clk) begin
      sclk_q <= sclk;
   end

   // clock rises since frame open; cleared while deselected
   always_ff @(posedge core_clk) begin
      if (rst || select_n) rise_cnt_q <= 16'h0;
      else if (sclk && !sclk_q) rise_cnt_q <= rise_cnt_q + 16'h1;
   end

   sequence s_open;
      $fell(select_n);
   endsequence
   sequence s_close;
      $rose(select_n);
   endsequence
   sequence s_quiet;
      !sclk [*5];
   endsequence

   // ----------------------------------------------------------
   // assertions
   // ----------------------------------------------------------
   a_open_quiet: assert property (s_open |-> s_quiet)
      else $error("clock moved at frame open");
   a_clk_framed: assert property ($changed(sclk) |-> !select_n)
      else $error("clock moved outside frame");
   a_close_whole: assert property (s_close |-> !sclk && rise_cnt_q[2:0] == 3'h0)
      else $error("frame closed mid byte");
   a_frame_gap: assert property (s_close |=> select_n [*3])
      else $error("gap between frames too short");
   a_cmd_hold: assert property (sclk && $past(sclk) |-> $stable(command_line))
      else $error("command bit moved while clock high");
   a_reply_hold: assert property (sclk && $past(sclk) && reply_oe && $past(reply_oe)
      |-> $stable(reply_o))
      else $error("reply bit moved while clock high");
   a_reply_start: assert property ($rose(reply_oe) |-> !select_n && rise_cnt_q >= 16'h8)
      else $error("reply driven before address done");
   a_reply_addr: assert property (!select_n && rise_cnt_q < 16'h8 |-> !reply_oe)
      else $error("reply driven in address phase");
   a_reply_free: assert property (select_n [*8] |-> !reply_oe)
      else $error("reply driven while deselected");
endmodule

// [verification/test_host_serial_register_port.sv]
// self-checking bench: host and device ends joined over the link
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin num_errors++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end

module test_host_serial_register_port;
   timeunit 1ns;
   timeprecision 1ns;
   import hsp_pkg::*;
   // ----------------------------------------------------------
   // signals
   // ----------------------------------------------------------
   logic        core_clk     = 1'b0;
   logic        rst          = 1'b1;
   logic        req_valid    = 1'b0;
   hsp_kind_t   req_kind     = HSP_CMD;
   logic [7:0]  req_addr     = 8'h00;
   logic [2:0]  req_bytes    = 3'h0;
   logic [7:0]  req_words    = 8'h00;
   logic [7:0]  status_flags = 8'h00;
   logic [7:0]  irq_mask     = 8'h00;
   logic [7:0]  wr_idx       = 8'h00;
   logic [7:0]  rd_cnt       = 8'h00;
   logic [7:0]  addr_q;
   logic [2:0]  reg_bytes;
   hsp_kind_t   reg_kind;
   logic        reg_stream, req_ready_q, wr_next_q, rd_valid_q, rd_auto_q, irq_seen_q;
   logic        cmd_stb_q, wr_stb_q, rd_stb_q;
   logic [31:0] wr_data, rd_data, wr_data_q, rd_data_q;
   logic [31:0] wr_q[$];
   logic [31:0] rd_q[$];
   logic        auto_q[$];
   int          num_errors      = 0;
   int          samples_checked = 0;
   int          cmd_cnt         = 0;
   int          cyc             = 0;

   always #50 core_clk = ~core_clk;

   hsp_if link ();
   hsp_device u_hsp_device (.core_clk, .rst, .bus(link), .addr_q, .reg_kind, .reg_bytes,
      .reg_stream, .cmd_stb_q, .wr_stb_q, .wr_data_q, .rd_stb_q, .rd_data, .status_flags,
      .irq_mask);
   hsp_host u_hsp_host (.core_clk, .rst, .bus(link), .req_valid, .req_ready_q, .req_kind,
      .req_addr, .req_bytes, .req_words, .wr_data, .wr_next_q, .rd_data_q, .rd_valid_q,
      .rd_auto_q, .irq_seen_q);
   hsp_link_monitor u_hsp_link_monitor (.core_clk, .rst, .sclk(link.sclk),
      .select_n(link.select_n), .command_line(link.command_line), .reply_o(link.reply_o),
      .reply_oe(link.reply_oe));

   // ----------------------------------------------------------
   // register map: addr[5:4] kind, addr[0] streams one byte, addr[7:6] width
   // ----------------------------------------------------------
   always_comb begin
      reg_stream = addr_q[0];
      reg_kind   = addr_q[5:4] == 2'h1 ? HSP_CMD : addr_q[5:4] == 2'h2 ? HSP_WR : HSP_RD;
      reg_bytes  = addr_q[5:4] == 2'h1 ? 3'h0 : addr_q[0] ? 3'h1 : {1'b0, addr_q[7:6]} + 3'h1;
      rd_data    = addr_q == 8'h00 ? {24'h0, status_flags} : {addr_q, 16'hC3E1, rd_cnt};
   end
   assign wr_data = {4{wr_idx}} ^ 32'h5A96C3E1;

   always @(posedge core_clk) begin
      cyc++;
      if (wr_next_q) wr_idx <= wr_idx + 8'h1;
      if (rd_stb_q) rd_cnt <= rd_cnt + 8'h1;
      if (cmd_stb_q) cmd_cnt++;
      if (wr_stb_q) wr_q.push_back(wr_data_q);
      if (rd_valid_q) rd_q.push_back(rd_data_q);
      if (rd_valid_q) auto_q.push_back(rd_auto_q);
      if (cyc == 20000) begin
         num_errors++;
         conclude();
      end
   end

   // ----------------------------------------------------------
   // tasks
   // ----------------------------------------------------------
   task automatic conclude();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // one request; n counts cycles until the host is ready again
   task automatic issue(input hsp_kind_t k, input logic [7:0] a, input logic [2:0] b,
                        input logic [7:0] w, output int n);
      n = 0;
      wr_q.delete();
      rd_q.delete();
      auto_q.delete();
      req_valid <= 1'b1;
      req_kind  <= k;
      req_addr  <= a;
      req_bytes <= b;
      req_words <= w;
      do @(posedge core_clk); while (req_ready_q !== 1'b1);
      req_valid <= 1'b0;
      @(posedge core_clk);
      while (req_ready_q !== 1'b1 && n < 5000) begin
         @(posedge core_clk);
         n++;
      end
   endtask

   task automatic t_basic();
      int n;
      int c0;
      logic [7:0] w0;
      logic [7:0] r0;
      c0 = cmd_cnt;
      issue(HSP_CMD, 8'h10, 3'h0, 8'h0, n);
      `CHK("cmd strobe", 1, cmd_cnt - c0)
      `CHK("cmd addr", 8'h10, addr_q)
      `CHK("cmd no data", 0, wr_q.size() + rd_q.size())
      w0 = wr_idx;
      issue(HSP_WR, 8'h60, 3'h2, 8'h1, n);
      `CHK("wr count", 1, wr_q.size())
      `CHK("wr word", ({4{w0}} ^ 32'h5A96C3E1) & 32'hFFFF, wr_q[0] & 32'hFFFF)
      `CHK("wr settle", 1, n >= 600)
      r0 = rd_cnt;
      issue(HSP_RD, 8'hF0, 3'h4, 8'h1, n);
      `CHK("rd count", 1, rd_q.size())
      `CHK("rd word", {8'hF0, 16'hC3E1, r0}, rd_q[0])
   endtask

   task automatic t_stream();
      int n;
      logic [7:0] w0;
      logic [7:0] r0;
      w0 = wr_idx;
      issue(HSP_WR, 8'h21, 3'h1, 8'h4, n);
      `CHK("stream wr count", 4, wr_q.size())
      for (int i = 0; i < 4; i++)
         `CHK("stream wr", 8'hE1 ^ (w0 + 8'(i)), wr_q[i] & 32'hFF)
      r0 = rd_cnt;
      issue(HSP_RD, 8'h31, 3'h1, 8'h3, n);
      `CHK("stream rd count", 3, rd_q.size())
      for (int i = 0; i < 3; i++)
         `CHK("stream rd", r0 + 8'(i), rd_q[i] & 32'hFF)
   endtask

   task automatic t_irq();
      int n;
      status_flags <= 8'h05;
      repeat (40) @(posedge core_clk);
      `CHK("irq masked", 1'b0, irq_seen_q)
      irq_mask <= 8'h04;
      repeat (5) @(posedge core_clk);
      `CHK("irq seen", 1'b1, irq_seen_q)
      `CHK("irq pin", 1'b0, link.irq_n)
      rd_q.delete();
      auto_q.delete();
      for (n = 0; n < 600 && rd_q.size() == 0; n++) @(posedge core_clk);
      `CHK("auto flag", 1'b1, auto_q[0])
      `CHK("status word", 8'h05, rd_q[0] & 32'hFF)
      status_flags <= 8'h00;
      repeat (600) @(posedge core_clk);
      `CHK("irq cleared", 1'b0, irq_seen_q)
   endtask

   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      t_basic();
      t_stream();
      t_irq();
      conclude();
   end
endmodule
